// ===== src/rss_cfg.svh
// timing and encoding constants for the reset source sequencer
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_CLK_HZ          50000000
`define RSS_START_DELAY_CYC 10
`define RSS_PIN_FILT_NS     200
`define RSS_PIN_FILT_CYC    ((`RSS_PIN_FILT_NS * 50 + 999) / 1000)
`define RSS_BRN_TRIP_NS     1000
`define RSS_BRN_TRIP_CYC    ((`RSS_BRN_TRIP_NS * 50 + 999) / 1000)
`define RSS_TIMER_1MS_CYC   50000
`define RSS_SYNC_IDLE       8'hE1
`define RSS_BRN_ALWAYS      2'b11
`define RSS_BRN_NOSLEEP     2'b10
`define RSS_BRN_SW          2'b01
`define RSS_BRN_OFF         2'b00
`endif

// ===== src/rss_pkg.sv
// types for the reset source sequencer
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_ST_HOLD  = 2'b00,
    RSS_ST_PWUP  = 2'b01,
    RSS_ST_DELAY = 2'b10,
    RSS_ST_RUN   = 2'b11
  } rss_state_e;
endpackage : rss_pkg

// ===== src/rss_reset_sequencer.sv
// reset source sequencing, start-up timing and cause flags
//
// Operation
// - programming-mode exit behaves like power-on reset
// - brown-out longer than trip duration resets, clears flag
// - mode 11 monitor always on, start waits ready
// - mode 11 sleep keeps monitor, wake not delayed
// - mode 10 off in sleep, wake waits ready
// - mode 01 software enable, no start wait
// - protection only when ready; ready flag reported
// - mode 00 monitor off, software enable ignored
// - mode 11 ready flag set before execution
// - pin reset enabled by low-voltage-prog or pin enable
// - pin reset clears ext_reset_flag_n unless it starts during the start delay
// - enabled pin held low keeps device in reset
// - pin filter rejects short low pulses
// - internal resets never drive the pin low
// - disabled pin is input, pull-up software controlled
// - watchdog timeout outside sleep resets and updates its flags
// - reset instruction resets and clears its flag
// - enabled stack over/underflow resets and sets flag
// - power-up timer holds reset up to 64 ms
// - timer enabled unless select 00, starts after release
// - execution waits timer done and pin release
// - execution starts 10 cycles after pin release
// - causing flag changes; hardware deactivates only timeout_flag_n and powerdown_flag_n
`include "rss_cfg.svh"
module rss_reset_sequencer #(
  parameter int unsigned TIMER_1MS_CYC = `RSS_TIMER_1MS_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       por_active,
  input  wire logic       prog_mode_exit,
  input  wire logic       bor_trip,
  input  wire logic       bor_monitor_ready,
  input  wire logic [1:0] bor_mode_select,
  input  wire logic       sw_bor_enable,
  input  wire logic       sleep_active,
  input  wire logic       wake_request,
  input  wire logic       ext_reset_pin_n,
  input  wire logic       ext_reset_pin_enable,
  input  wire logic       low_voltage_prog_enable,
  input  wire logic       sw_pullup_enable,
  input  wire logic       watchdog_timeout,
  input  wire logic       clear_watchdog_instr,
  input  wire logic       sleep_instr,
  input  wire logic       reset_instr,
  input  wire logic       stack_reset_enable,
  input  wire logic       stack_overflow,
  input  wire logic       stack_underflow,
  input  wire logic [1:0] powerup_timer_select,
  input  wire logic       sw_flag_write,
  input  wire logic [7:0] sw_flag_data,
  output logic            core_reset,
  output logic            core_run,
  output logic            bor_monitor_enable,
  output logic            bor_ready_flag,
  output logic            ext_reset_pin_oe_n,
  output logic            ext_reset_pin_out,
  output logic            ext_reset_pullup,
  output logic            ext_pin_gpio_in,
  output logic            brownout_reset_n,
  output logic            poweron_reset_n,
  output logic            ext_reset_flag_n,
  output logic            timeout_flag_n,
  output logic            powerdown_flag_n,
  output logic            wdt_reset_flag_n,
  output logic            reset_instr_flag_n,
  output logic            stack_over_flag,
  output logic            stack_under_flag
);

  // the 64 ms count must still fit the 32-bit timer
  if (TIMER_1MS_CYC < 1 || TIMER_1MS_CYC > 32'h03FF_FFFF)
  begin : g_bad_timer
    $error("TIMER_1MS_CYC out of range");
  end

  // pin, monitor and async event inputs are two-stage synchronised
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic       pin_s, trip_s, rdy_s, por_s, prog_s;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // idle pin levels, so no false event follows reset
      sync1_q <= `RSS_SYNC_IDLE;
      sync2_q <= `RSS_SYNC_IDLE;
    end
    else
    begin
      sync1_q <= {3'h7, prog_mode_exit, por_active, bor_monitor_ready, bor_trip,
                  ext_reset_pin_n};
      sync2_q <= sync1_q;
    end
  end
  assign pin_s  = sync2_q[0];
  assign trip_s = sync2_q[1];
  assign rdy_s  = sync2_q[2];
  assign por_s  = sync2_q[3];
  assign prog_s = sync2_q[4];

  logic pin_en;
  assign pin_en = low_voltage_prog_enable | ext_reset_pin_enable;

  // low filter: short pulses never reach the reset path
  logic [7:0] pin_cnt_q;
  logic       pin_low_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_cnt_q <= 8'h00;
      pin_low_q <= 1'b0;
    end
    else if (pin_s || !pin_en)
    begin
      pin_cnt_q <= 8'h00;
      pin_low_q <= 1'b0;
    end
    else if (pin_cnt_q < 8'(`RSS_PIN_FILT_CYC))
      pin_cnt_q <= pin_cnt_q + 8'h01;
    else
      pin_low_q <= 1'b1;
  end

  // brown-out monitor enable per mode
  logic bor_on;
  always_comb
  begin
    case (bor_mode_select)
      `RSS_BRN_ALWAYS:  bor_on = 1'b1;
      `RSS_BRN_NOSLEEP: bor_on = !sleep_active;
      `RSS_BRN_SW:      bor_on = sw_bor_enable;
      default:          bor_on = 1'b0;
    endcase
  end
  logic armed;
  assign armed = bor_on & rdy_s;

  logic [7:0] trip_cnt_q;
  logic       bor_hit_q;
  always_ff @(posedge clk)
  begin
    if (rst || !armed || !trip_s)
    begin
      trip_cnt_q <= 8'h00;
      bor_hit_q  <= 1'b0;
    end
    else if (trip_cnt_q < 8'(`RSS_BRN_TRIP_CYC))
      trip_cnt_q <= trip_cnt_q + 8'h01;
    else
      bor_hit_q <= 1'b1;
  end

  logic stk_ev, wdt_ev, ext_ev, cold_ev, bor_ev;
  assign stk_ev  = stack_reset_enable & (stack_overflow | stack_underflow);
  assign wdt_ev  = watchdog_timeout & !sleep_active;
  assign ext_ev  = pin_low_q;
  assign bor_ev  = bor_hit_q;
  assign cold_ev = por_s | prog_s;

  // start-up sequencing
  rss_pkg::rss_state_e st_q;
  logic [31:0] pwup_cnt_q;
  logic [3:0]  dly_q;
  logic [31:0] pwup_len;
  logic        cold_q;
  logic        start_gate;
  always_comb
  begin
    case (powerup_timer_select)
      2'h1:    pwup_len = TIMER_1MS_CYC;
      2'h2:    pwup_len = TIMER_1MS_CYC * 16;
      2'h3:    pwup_len = TIMER_1MS_CYC * 64;
      default: pwup_len = 32'h0000_0000;
    endcase
  end
  // modes 11/10 hold start-up until the monitor is ready and supply ok
  assign start_gate = (bor_mode_select[1] ? (rdy_s & !trip_s) : 1'b1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q       <= rss_pkg::RSS_ST_HOLD;
      pwup_cnt_q <= 32'h0000_0000;
      dly_q      <= 4'h0;
      cold_q     <= 1'b1;
    end
    else if (cold_ev || bor_ev)
    begin
      st_q       <= rss_pkg::RSS_ST_HOLD;
      pwup_cnt_q <= 32'h0000_0000;
      cold_q     <= 1'b1;
    end
    else if (wdt_ev || reset_instr || stk_ev)
    begin
      st_q   <= rss_pkg::RSS_ST_HOLD;
      cold_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        rss_pkg::RSS_ST_HOLD:
        begin
          if (start_gate)
            st_q <= (cold_q && pwup_len != 32'h0) ? rss_pkg::RSS_ST_PWUP
                                                 : rss_pkg::RSS_ST_DELAY;
          pwup_cnt_q <= 32'h0000_0000;
          dly_q      <= 4'h0;
        end
        rss_pkg::RSS_ST_PWUP:
        begin
          // runs regardless of the pin level
          if (pwup_cnt_q + 32'h1 >= pwup_len)
            st_q <= rss_pkg::RSS_ST_DELAY;
          pwup_cnt_q <= pwup_cnt_q + 32'h0000_0001;
        end
        rss_pkg::RSS_ST_DELAY:
        begin
          if (ext_ev)
            dly_q <= 4'h0;
          else if (dly_q == 4'(`RSS_START_DELAY_CYC - 1))
          begin
            st_q   <= rss_pkg::RSS_ST_RUN;
            cold_q <= 1'b0;
          end
          else
            dly_q <= dly_q + 4'h1;
        end
        rss_pkg::RSS_ST_RUN:
        begin
          if (ext_ev)
            st_q <= rss_pkg::RSS_ST_DELAY;
          dly_q <= 4'h0;
          // wake in mode 10 waits on the monitor; mode 11 does not
          if (sleep_active && wake_request && bor_mode_select == `RSS_BRN_NOSLEEP
              && !(rdy_s && !trip_s))
            st_q <= rss_pkg::RSS_ST_HOLD;
        end
        default: st_q <= rss_pkg::RSS_ST_HOLD;
      endcase
    end
  end

  // outputs, all registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_reset         <= 1'b1;
      core_run           <= 1'b0;
      bor_monitor_enable <= 1'b0;
      bor_ready_flag     <= 1'b0;
      ext_reset_pin_oe_n <= 1'b1;
      ext_reset_pin_out  <= 1'b1;
      ext_reset_pullup   <= 1'b1;
      ext_pin_gpio_in    <= 1'b1;
    end
    else
    begin
      core_reset         <= (st_q != rss_pkg::RSS_ST_RUN);
      core_run           <= (st_q == rss_pkg::RSS_ST_RUN);
      bor_monitor_enable <= bor_on;
      bor_ready_flag     <= armed;
      ext_reset_pin_oe_n <= 1'b1;
      ext_reset_pin_out  <= 1'b1;
      ext_reset_pullup   <= pin_en ? 1'b1 : sw_pullup_enable;
      ext_pin_gpio_in    <= pin_en ? 1'b1 : pin_s;
    end
  end

  // cause flags: hardware drives the active value of the causing source; cold reset also drives timeout_flag_n and powerdown_flag_n inactive
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      brownout_reset_n   <= 1'b0;
      poweron_reset_n    <= 1'b0;
      ext_reset_flag_n   <= 1'b1;
      timeout_flag_n     <= 1'b1;
      powerdown_flag_n   <= 1'b1;
      wdt_reset_flag_n   <= 1'b1;
      reset_instr_flag_n <= 1'b1;
      stack_over_flag    <= 1'b0;
      stack_under_flag   <= 1'b0;
    end
    else
    begin
      // software write first, hardware events below win
      if (sw_flag_write)
      begin
        brownout_reset_n   <= sw_flag_data[0];
        poweron_reset_n    <= sw_flag_data[1];
        reset_instr_flag_n <= sw_flag_data[2];
        ext_reset_flag_n   <= sw_flag_data[3];
        wdt_reset_flag_n   <= sw_flag_data[4];
        stack_under_flag   <= sw_flag_data[6];
        stack_over_flag    <= sw_flag_data[7];
      end
      if (clear_watchdog_instr)
      begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
      if (sleep_instr)
      begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b0;
      end
      if (cold_ev)
      begin
        poweron_reset_n  <= 1'b0;
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
      if (bor_ev)
        brownout_reset_n <= 1'b0;
      if (ext_ev && st_q != rss_pkg::RSS_ST_DELAY)
        ext_reset_flag_n <= 1'b0;
      if (watchdog_timeout)
      begin
        timeout_flag_n <= 1'b0;
        if (!sleep_active)
          wdt_reset_flag_n <= 1'b0;
      end
      if (reset_instr)
        reset_instr_flag_n <= 1'b0;
      if (stk_ev && stack_overflow)
        stack_over_flag <= 1'b1;
      if (stk_ev && stack_underflow)
        stack_under_flag <= 1'b1;
    end
  end

endmodule : rss_reset_sequencer

// ===== sim/rss_props.sv
// assertion checker for the reset source sequencer
module rss_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       por_active,
  input wire logic       ext_reset_pin_n,
  input wire logic       ext_reset_pin_enable,
  input wire logic       low_voltage_prog_enable,
  input wire logic       watchdog_timeout,
  input wire logic       sleep_active,
  input wire logic       reset_instr,
  input wire logic       stack_reset_enable,
  input wire logic       stack_overflow,
  input wire logic [1:0] bor_mode_select,
  input wire logic       core_reset,
  input wire logic       core_run,
  input wire logic       bor_monitor_enable,
  input wire logic       ext_reset_pin_oe_n,
  input wire logic       ext_reset_flag_n,
  input wire logic       wdt_reset_flag_n,
  input wire logic       reset_instr_flag_n,
  input wire logic       stack_over_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // saturating count of enabled low cycles, beyond filter plus sync
  always_ff @(posedge clk)
    if (rst || ext_reset_pin_n || !(ext_reset_pin_enable || low_voltage_prog_enable))
      low_q <= 5'h00;
    else if (low_q != 5'h1F)
      low_q <= low_q + 5'h01;
  a_pin_undriven: assert property (ext_reset_pin_oe_n)
    else $error("reset pin driven");
  a_por_holds: assert property (por_active [*5] |-> core_reset)
    else $error("power-on not held");
  a_pin_holds: assert property (low_q >= 5'h10 |-> core_reset && !ext_reset_flag_n)
    else $error("pin low not held");
  a_instr_resets: assert property (reset_instr && core_run
    |-> ##[1:4] (core_reset && !reset_instr_flag_n)) else $error("reset instr missed");
  a_wdt_resets: assert property (watchdog_timeout && core_run && !sleep_active
    |-> ##[1:4] (core_reset && !wdt_reset_flag_n)) else $error("watchdog missed");
  a_stack_resets: assert property (stack_overflow && stack_reset_enable && core_run
    |-> ##[1:4] (core_reset && stack_over_flag)) else $error("overflow missed");
  a_start_delay: assert property ($fell(core_reset) |-> $past(ext_reset_pin_n, 10))
    else $error("start too soon");
  a_bor_off: assert property ($past(bor_mode_select) == 2'h0 && !$past(rst)
    |-> !bor_monitor_enable) else $error("monitor on in off mode");
  a_bor_on: assert property ($past(bor_mode_select) == 2'h3 && !$past(rst)
    |-> bor_monitor_enable) else $error("monitor off in always mode");
  c_start: cover property (core_run && $past(core_reset));
  c_pin: cover property (core_reset && !ext_reset_flag_n);
  c_stack: cover property (stack_over_flag);
endmodule : rss_props

bind rss_reset_sequencer rss_props u_props (.*);

// ===== sim/rss_supply_model.sv
// supply monitors and external reset pin driver
module rss_supply_model (
  input  wire logic clk,
  input  wire logic bor_monitor_enable,
  output logic      por_active,
  output logic      bor_trip,
  output logic      bor_monitor_ready,
  output logic      pin_drive_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] act_q = 3'h0;
  logic [1:0] warm_q = 2'h0;
  // analog monitor needs a warm-up after enable, so ready is never instant
  always_ff @(posedge clk)
    if (!bor_monitor_enable)
      warm_q <= 2'h0;
    else if (warm_q != 2'h3)
      warm_q <= warm_q + 2'h1;
  assign bor_monitor_ready = warm_q == 2'h3;
  assign por_active = act_q[0];
  assign bor_trip = act_q[1];
  assign pin_drive_n = !act_q[2];
  // released pin is driven high through pin_drive_n; no pull-up is modelled
  task automatic pulse(input int sel, input int n);
    @(negedge clk);
    act_q[sel] = 1'h1;
    repeat (n) @(negedge clk);
    act_q[sel] = 1'h0;
  endtask : pulse
endmodule : rss_supply_model

// ===== sim/rss_reset_sequencer_tb.sv
// self-checking testbench for the reset source sequencer
module rss_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, prog_mode_exit, sw_bor_enable, sleep_active, wake_request;
  logic       ext_reset_pin_enable, low_voltage_prog_enable, sw_pullup_enable;
  logic       watchdog_timeout, clear_watchdog_instr, sleep_instr, reset_instr;
  logic       stack_reset_enable, stack_overflow, stack_underflow, sw_flag_write;
  logic [1:0] bor_mode_select, powerup_timer_select;
  logic [7:0] sw_flag_data;
  logic       core_reset, core_run, bor_monitor_enable, bor_ready_flag, ext_reset_pin_oe_n;
  logic       ext_reset_pin_out, ext_reset_pullup, ext_pin_gpio_in, brownout_reset_n;
  logic       poweron_reset_n, ext_reset_flag_n, timeout_flag_n, powerdown_flag_n;
  logic       wdt_reset_flag_n, reset_instr_flag_n, stack_over_flag, stack_under_flag;
  logic       por_active, bor_trip, bor_monitor_ready, pin_drive_n;
  wire logic  ext_reset_pin_n = ext_reset_pin_oe_n ? pin_drive_n : ext_reset_pin_out;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  // short timer unit keeps the run brief
  rss_reset_sequencer #(.TIMER_1MS_CYC(20)) uut (.*);
  rss_supply_model pm (.*);
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wait_run(output int n);
    n = 0;
    while (core_run !== 1'h1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk(core_run, 1'h1);
  endtask : wait_run
  task automatic flags(input logic [7:0] d);
    sw_flag_data = d;
    sw_flag_write = 1'h1;
    @(negedge clk);
    sw_flag_write = 1'h0;
    @(negedge clk);
  endtask : flags
  task automatic t_power;
    int n;
    bor_mode_select = 2'h3;
    powerup_timer_select = 2'h1;
    pm.pulse(0, 8);
    wait_run(n);
    chk(n >= 30, 1'h1);
    chk(bor_ready_flag, 1'h1);
    flags(8'h1F);
    powerup_timer_select = 2'h0;
    prog_mode_exit = 1'h1;
    idle(2);
    prog_mode_exit = 1'h0;
    idle(4);
    wait_run(n);
    chk(n < 26, 1'h1);
    chk(poweron_reset_n, 1'h0);
    $display("power-up test done");
  endtask : t_power
  task automatic t_pin;
    int n;
    flags(8'h1F);
    pm.pulse(2, 4);
    idle(20);
    chk({core_run, ext_reset_flag_n}, 2'h3);
    pm.pulse(2, 30);
    chk({core_reset, ext_reset_flag_n}, 2'h2);
    wait_run(n);
    chk(n >= 10 && n < 20, 1'h1);
    flags(8'h1F);
    ext_reset_pin_enable = 1'h0;
    sw_pullup_enable = 1'h0;
    pm.pulse(2, 30);
    chk({core_run, ext_reset_flag_n, ext_reset_pullup, ext_pin_gpio_in}, 4'hC);
    low_voltage_prog_enable = 1'h1;
    pm.pulse(2, 30);
    chk({core_reset, ext_reset_flag_n}, 2'h2);
    wait_run(n);
    $display("pin reset test done");
  endtask : t_pin
  task automatic t_internal;
    int n;
    logic [7:0] obs;
    logic [3:0] ev[5] = '{4'h1, 4'h2, 4'h4, 4'h4, 4'h8};
    logic [7:0] exp[5] = '{8'h1B, 8'h0F, 8'h1F, 8'h9F, 8'h5F};
    for (int i = 0; i < 5; i++)
    begin
      clear_watchdog_instr = 1'h1;
      flags(8'h1F);
      clear_watchdog_instr = 1'h0;
      stack_reset_enable = i != 2;
      {stack_underflow, stack_overflow, watchdog_timeout, reset_instr} = ev[i];
      @(negedge clk);
      {stack_underflow, stack_overflow, watchdog_timeout, reset_instr} = 4'h0;
      idle(3);
      chk(core_reset, i != 2);
      chk({ext_reset_pin_n, ext_reset_pin_oe_n, ext_reset_pin_out}, 3'h7);
      chk(timeout_flag_n, i != 1);
      obs = {stack_over_flag, stack_under_flag, 1'h0, wdt_reset_flag_n, ext_reset_flag_n,
             reset_instr_flag_n, poweron_reset_n, brownout_reset_n};
      chk(obs, exp[i]);
      wait_run(n);
    end
    $display("internal reset test done");
  endtask : t_internal
  task automatic t_bor;
    int n;
    flags(8'h1F);
    bor_mode_select = 2'h0;
    sw_bor_enable = 1'h1;
    pm.pulse(1, 100);
    chk({core_run, bor_monitor_enable}, 2'h2);
    bor_mode_select = 2'h1;
    sw_bor_enable = 1'h0;
    idle(3);
    chk(bor_monitor_enable, 1'h0);
    sw_bor_enable = 1'h1;
    idle(8);
    chk({bor_monitor_enable, bor_ready_flag}, 2'h3);
    bor_mode_select = 2'h2;
    pm.pulse(1, 20);
    idle(3);
    chk({core_run, brownout_reset_n}, 2'h3);
    pm.pulse(1, 80);
    chk({core_reset, brownout_reset_n}, 2'h2);
    wait_run(n);
    chk(bor_ready_flag, 1'h1);
    $display("brown-out test done");
  endtask : t_bor
  task automatic t_sleep;
    int n;
    sleep_instr = 1'h1;
    @(negedge clk);
    sleep_instr = 1'h0;
    sleep_active = 1'h1;
    idle(3);
    chk({powerdown_flag_n, timeout_flag_n, bor_monitor_enable}, 3'h2);
    flags(8'h1F);
    watchdog_timeout = 1'h1;
    @(negedge clk);
    watchdog_timeout = 1'h0;
    idle(2);
    chk({core_run, timeout_flag_n, wdt_reset_flag_n}, 3'h5);
    wake_request = 1'h1;
    @(negedge clk);
    wake_request = 1'h0;
    sleep_active = 1'h0;
    idle(2);
    chk(core_reset, 1'h1);
    wait_run(n);
    chk({core_run, bor_ready_flag}, 2'h3);
    bor_mode_select = 2'h3;
    sleep_active = 1'h1;
    idle(3);
    chk(bor_monitor_enable, 1'h1);
    wake_request = 1'h1;
    @(negedge clk);
    wake_request = 1'h0;
    sleep_active = 1'h0;
    idle(2);
    chk(core_run, 1'h1);
    $display("sleep test done");
  endtask : t_sleep
  initial
  begin
    rst = 1'h1;
    {prog_mode_exit, sw_bor_enable, sleep_active, wake_request, low_voltage_prog_enable} = '0;
    {watchdog_timeout, clear_watchdog_instr, sleep_instr, reset_instr, stack_reset_enable} = '0;
    {stack_overflow, stack_underflow, sw_flag_write, sw_flag_data} = '0;
    {bor_mode_select, powerup_timer_select} = '0;
    {ext_reset_pin_enable, sw_pullup_enable} = 2'h3;
    idle(4);
    rst = 1'h0;
    t_power();
    t_pin();
    t_internal();
    t_bor();
    t_sleep();
    end_sim();
  end
endmodule : rss_reset_sequencer_tb
